/* dv/rbc_follower_bench.sv */
`timescale 1ns/100ps
module rbc_follower_bench;
  import rbc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic fstart = 1'b0;
  logic dvalid = 1'b0;
  logic [7:0] data = 8'h00;
  logic [15:0] head = 16'h0000;
  logic ext_we = 1'b0;
  logic [15:0] ext_addr = 16'h0000;
  logic [15:0] ext_val = 16'h0000;
  rbc_rd_req_s rd_req;
  rbc_wr_req_s wr_req;
  logic rd_valid, rd_ready, rd_dv, dready, wr_valid, wr_ready, nxt, no_buf;
  logic [15:0] rd_data, chain;
  rbc_wr_req_s wq [$];
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  rbc_follower dut (.i_sys_clk(clk), .i_rst(rst), .i_start(start), .i_head_addr(head),
    .i_rd_ready(rd_ready), .o_rd_req(rd_req), .o_rd_valid(rd_valid),
    .i_rd_data_valid(rd_dv), .i_rd_data(rd_data), .i_frame_start(fstart),
    .i_data_valid(dvalid), .i_data(data), .o_data_ready(dready), .o_wr_req(wr_req),
    .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_rx_chain_next_valid(nxt),
    .o_no_buffer(no_buf), .o_chain_addr(chain));
  rbc_mem_model mem (.i_sys_clk(clk), .i_ext_we(ext_we), .i_ext_addr(ext_addr),
    .i_ext_val(ext_val), .i_rd_req(rd_req), .i_rd_valid(rd_valid), .o_rd_ready(rd_ready),
    .o_rd_data_valid(rd_dv), .o_rd_data(rd_data), .o_wr_ready(wr_ready));
  // capture every data write that the coming edge accepts; both sides settled
  always @(negedge clk) begin
    if (wr_valid & wr_ready) wq.push_back(wr_req);
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse_start(input logic [15:0] h, input logic fr);
    head = h;
    start = ~fr;
    fstart = fr;
    step(1);
    start = 1'b0;
    fstart = 1'b0;
  endtask
  // bounded wait for the link answer, then let the state land
  task automatic wait_rd();
    for (int i = 0; i < 60 && rd_dv !== 1'b1; i++) step(1);
    step(2);
  endtask
  task automatic link(input logic [15:0] a, input logic [15:0] v);
    ext_addr = a;
    ext_val = v;
    ext_we = 1'b1;
    step(1);
    ext_we = 1'b0;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    wq.delete();
  endtask
  // hold the byte until ready stands high, then let one edge take it
  task automatic send_byte(input logic [7:0] b, input logic last);
    int i;
    data = b;
    dvalid = 1'b1;
    for (i = 0; i < 60 && dready !== 1'b1; i++) step(1);
    chk(24'(dready), 24'h1);
    step(1);
    if (last) dvalid = 1'b0;
  endtask
  task automatic test_chain();
    link(16'h0010, 16'h0200);
    do_reset();
    pulse_start(16'h0010, 1'b0);
    wait_rd();
    chk(24'(nxt), 24'h1);
    chk(24'(chain), 24'h0200);
    pulse_start(16'h0010, 1'b1);
    send_byte(8'ha5, 1'b0);
    send_byte(8'h5a, 1'b1);
    step(30);
    chk(24'(wq.size()), 24'h2);
    chk(wq[0], {16'h0202, 8'ha5});
    chk(wq[1], {16'h0203, 8'h5a});
    chk(24'(nxt), 24'h0);
    chk(24'(chain), 24'h0200);
    $display("test chain done");
  endtask
  task automatic test_park();
    do_reset();
    pulse_start(16'h0030, 1'b0);
    wait_rd();
    chk(24'(nxt), 24'h0);
    chk(24'(chain), 24'h0030);
    pulse_start(16'h0030, 1'b1);
    wait_rd();
    data = 8'h3c;
    dvalid = 1'b1;
    step(5);
    chk(24'(no_buf), 24'h1);
    chk({dready, 23'(wq.size())}, 24'h0);
    link(16'h0030, 16'h0100);
    pulse_start(16'h0030, 1'b1);
    send_byte(8'h3c, 1'b1);
    step(30);
    chk(24'(wq.size()), 24'h1);
    chk(wq[0], {16'h0102, 8'h3c});
    $display("test park done");
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    step(2);
    rst = 1'b0;
    test_chain();
    test_park();
    print_verdict();
  end
endmodule

/* dv/rbc_mem_model.sv */
`timescale 1ns/100ps
// host memory holding the link fields; data writes are taken and dropped
module rbc_mem_model
  import rbc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_ext_we,
  input wire logic [ADDR_W-1:0] i_ext_addr,
  input wire logic [ADDR_W-1:0] i_ext_val,
  input rbc_rd_req_s i_rd_req,
  input wire logic i_rd_valid,
  output logic o_rd_ready,
  output logic o_rd_data_valid,
  output logic [ADDR_W-1:0] o_rd_data,
  output logic o_wr_ready
);
  logic [ADDR_W-1:0] link_mem [0:255];
  logic [1:0] tick = 2'h0;
  initial begin
    o_rd_data_valid = 1'b0;
    o_rd_data = 16'h0000;
    foreach (link_mem[i]) link_mem[i] = 16'h0000;
  end
  // stalls on both buses so prompt and slow answers occur
  assign o_rd_ready = tick[0];
  assign o_wr_ready = tick[1];
  // one cycle read latency; a released data line flips so stale data never looks valid
  always @(posedge i_sys_clk) begin
    tick <= tick + 2'h1;
    if (i_ext_we) link_mem[i_ext_addr[11:4]] <= i_ext_val;
    o_rd_data_valid <= i_rd_valid & o_rd_ready;
    if (i_rd_valid & o_rd_ready) o_rd_data <= link_mem[i_rd_req.addr[11:4]];
    else o_rd_data <= ~o_rd_data;
  end
endmodule

/* logic/rbc_follower.sv */
`timescale 1ns/100ps
// How it works
// RL1: keep stepping along the list so the next buffer address is ready early.
// RL2: chain register holds either next buffer address or prior link field address.
// RL3: a zero link read parks the follower at that link field address.
// RL4: host extends the chain by writing a nonzero buffer address into last link.
// RL5: when a buffer is needed while parked, re-read the link field from memory.
// RL6: set the chain state flag while the next buffer address is held.
// RL7: clear the chain state flag once the register advanced to a zero link.
// RL8: if the re-read link is still zero, write no data and stay parked; after a first buffer, bytes taken before that answer are still written.
module rbc_follower
  import rbc_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [ADDR_W-1:0] i_head_addr,
  input wire logic i_rd_ready,
  output rbc_rd_req_s o_rd_req,
  output logic o_rd_valid,
  input wire logic i_rd_data_valid,
  input wire logic [ADDR_W-1:0] i_rd_data,
  input wire logic i_frame_start,
  input wire logic i_data_valid,
  input wire logic [DATA_W-1:0] i_data,
  output logic o_data_ready,
  output rbc_wr_req_s o_wr_req,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic o_rx_chain_next_valid,
  output logic o_no_buffer,
  output logic [ADDR_W-1:0] o_chain_addr
);

  // ************************************************************
  // chain walker
  // ************************************************************
  rbc_state_e state_reg;
  logic [ADDR_W-1:0] chain_reg;
  logic [ADDR_W-1:0] cur_buf_reg;
  logic [ADDR_W-1:0] wr_ptr_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic need_reg;
  logic have_buf_reg;
  logic rd_valid_reg;
  logic flag_reg;
  logic no_buf_reg;
  logic buf_push;
  logic buf_full;

  // the walk only looks ahead one buffer; frame start consumes it
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= ST_LOAD_ADDR;
      chain_reg <= RST_ADDR;
      cur_buf_reg <= RST_ADDR;
      rd_addr_reg <= RST_ADDR;
      need_reg <= 1'b0;
      have_buf_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      flag_reg <= 1'b0;
      no_buf_reg <= 1'b0;
    end else begin
      if (i_frame_start && !need_reg) begin
        need_reg <= 1'b1;
      end
      case (state_reg)
        ST_LOAD_ADDR: begin
          if (i_start) begin
            chain_reg <= i_head_addr;
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // read link field of the buffer that chain_reg names
          rd_valid_reg <= 1'b1;
          rd_addr_reg <= chain_reg + LINK_OFS; // [RL2]
          state_reg <= ST_WAIT_RD;
        end
        ST_WAIT_RD: begin
          if (rd_valid_reg && i_rd_ready) begin
            rd_valid_reg <= 1'b0;
          end
          if (i_rd_data_valid) begin
            if (i_rd_data == ZERO_LINK) begin
              state_reg <= ST_PARKED; // [RL3]
              flag_reg <= 1'b0; // [RL7]
              if (need_reg) begin
                no_buf_reg <= 1'b1; // [RL8]
                // a frame start in this very cycle is a fresh request and wins
                need_reg <= i_frame_start;
              end
            end else begin
              chain_reg <= i_rd_data; // [RL1] [RL2]
              flag_reg <= 1'b1; // [RL6]
              no_buf_reg <= 1'b0;
              state_reg <= ST_HOLD_NEXT;
            end
          end
        end
        ST_HOLD_NEXT: begin
          if (need_reg) begin
            // take the held buffer, then step ahead at once
            cur_buf_reg <= chain_reg;
            have_buf_reg <= 1'b1;
            need_reg <= i_frame_start;
            state_reg <= ST_FETCH; // [RL1]
          end
        end
        ST_PARKED: begin
          if (need_reg) begin
            state_reg <= ST_FETCH; // [RL5]
          end
        end
        default: begin
          state_reg <= ST_LOAD_ADDR;
        end
      endcase
    end
  end

  // ************************************************************
  // two-entry data buffer
  // ************************************************************
  logic [DATA_W-1:0] mem_reg [BUF_DEPTH];
  logic [$clog2(BUF_DEPTH):0] cnt_reg;
  logic [$clog2(BUF_DEPTH)-1:0] rp_reg;
  logic [$clog2(BUF_DEPTH)-1:0] wp_reg;
  logic buf_pop;
  logic data_rdy_reg;

  assign buf_full = (cnt_reg == ($clog2(BUF_DEPTH)+1)'(BUF_DEPTH));
  // data only accepted while a buffer is owned; otherwise it is held back
  assign buf_push = i_data_valid && data_rdy_reg;
  // an entry leaves the buffer when it moves into the write stage, so the
  // stage never reloads the word it is still offering
  assign buf_pop = have_buf_reg && (cnt_reg != '0) && (!wr_valid_reg || i_wr_ready);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
      rp_reg <= '0;
      wp_reg <= '0;
    end else begin
      if (buf_push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (buf_pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{$clog2(BUF_DEPTH){1'b0}}, buf_push}
        - {{$clog2(BUF_DEPTH){1'b0}}, buf_pop};
    end
  end

  for (genvar g = 0; g < BUF_DEPTH; g++) begin : g_ent
    always_ff @(posedge i_sys_clk) begin
      if (buf_push && wp_reg == g) begin
        mem_reg[g] <= i_data;
      end
    end
  end

  // ready registered; conservative by one slot so push never overflows
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      data_rdy_reg <= 1'b0;
    end else begin
      // no new bytes while the re-read link was still zero
      data_rdy_reg <= have_buf_reg && !no_buf_reg && !buf_full // [RL8]
        && (cnt_reg + {{$clog2(BUF_DEPTH){1'b0}}, buf_push}
        < ($clog2(BUF_DEPTH)+1)'(BUF_DEPTH));
    end
  end

  // ************************************************************
  // memory writer
  // ************************************************************
  logic wr_valid_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic [ADDR_W-1:0] wr_addr_reg;

  // a stalled write holds; a new word loads only once the last one went
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_valid_reg <= 1'b0;
      wr_data_reg <= '0;
      wr_addr_reg <= RST_ADDR;
      wr_ptr_reg <= RST_ADDR;
    end else begin
      if (state_reg == ST_HOLD_NEXT && need_reg) begin
        wr_ptr_reg <= chain_reg + DATA_OFS;
      end
      if (buf_pop) begin
        wr_valid_reg <= 1'b1; // [RL8]
        wr_data_reg <= mem_reg[rp_reg];
        wr_addr_reg <= wr_ptr_reg;
        wr_ptr_reg <= wr_ptr_reg + ADDR_ONE;
      end else if (i_wr_ready) begin
        wr_valid_reg <= 1'b0;
      end
    end
  end

  assign o_wr_valid = wr_valid_reg;
  assign o_wr_req = '{addr: wr_addr_reg, data: wr_data_reg};
  assign o_rd_valid = rd_valid_reg;
  assign o_rd_req = '{addr: rd_addr_reg};
  assign o_data_ready = data_rdy_reg;
  assign o_rx_chain_next_valid = flag_reg;
  assign o_no_buffer = no_buf_reg;
  assign o_chain_addr = chain_reg;

  // ************************************************************
  // checks
  // ************************************************************
  AST_ZERO_PARKS: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RL3]
    state_reg == ST_WAIT_RD && i_rd_data_valid && i_rd_data == ZERO_LINK
    |=> state_reg == ST_PARKED && $stable(chain_reg))
    else $error("zero link did not park");
  AST_FLAG_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RL7]
    state_reg == ST_PARKED |-> !o_rx_chain_next_valid)
    else $error("flag set while parked");
  AST_FLAG_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RL6]
    state_reg == ST_HOLD_NEXT |-> o_rx_chain_next_valid)
    else $error("flag clear while next held");
  AST_ADVANCE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RL1]
    state_reg == ST_WAIT_RD && i_rd_data_valid && i_rd_data != ZERO_LINK
    |=> chain_reg == $past(i_rd_data))
    else $error("chain did not advance");
  AST_REFETCH: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RL5]
    state_reg == ST_PARKED && need_reg |=> state_reg == ST_FETCH ##1 o_rd_valid)
    else $error("no re-read when parked");
  AST_NO_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RL8]
    !have_buf_reg |-> !o_wr_valid)
    else $error("write without buffer");
  COV_PARK: cover property (@(posedge i_sys_clk) state_reg == ST_PARKED);
  COV_RESUME: cover property (@(posedge i_sys_clk)
    state_reg == ST_PARKED ##[1:50] state_reg == ST_HOLD_NEXT);
  COV_WRITE: cover property (@(posedge i_sys_clk) o_wr_valid && i_wr_ready);

endmodule

/* pkg/rbc_pkg.sv */
package rbc_pkg;

  // ************************************************************
  // widths and fixed values
  // ************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ZERO_LINK = 16'h0000;
  localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;
  // link field offset inside a buffer, arbitrary default
  localparam logic [ADDR_W-1:0] LINK_OFS = 16'h0000;
  localparam logic [ADDR_W-1:0] DATA_OFS = 16'h0002;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;

  // memory read request (address only)
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } rbc_rd_req_s;

  // memory write request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rbc_wr_req_s;

  typedef enum logic [2:0] {
    ST_LOAD_ADDR,
    ST_FETCH,
    ST_WAIT_RD,
    ST_HOLD_NEXT,
    ST_PARKED
  } rbc_state_e;

endpackage
